// ### inc/sar_adc_map.vh
// Register map, field positions and timing constants of the converter control
`ifndef SAR_ADC_MAP_VH
`define SAR_ADC_MAP_VH
`define ADDR_RESULT_LO 16'hff16
`define ADDR_RESULT_HI 16'hff17
`define ADDR_MODE 16'hff80
`define ADDR_CHAN 16'hff81
`define MODE_RESET 8'h00
`define CHAN_RESET 8'h00
`define RESULT_RESET 16'h0000
`define BIT_RUN 7
`define BIT_SRC 6
`define BIT_TIME_HI 5
`define BIT_TIME_LO 3
`define BIT_EDGE_HI 2
`define BIT_EDGE_LO 1
`define BIT_REFGEN 0
`define CHAN_MASK 8'h07
`define CONV_144 8'd144
`define CONV_120 8'd120
`define CONV_96 8'd96
`define CONV_72 8'd72
`define CONV_60 8'd60
`define CONV_48 8'd48
`define SAMPLE_CYC 8'd8
`define SAR_BITS 10
`endif

// ### design/trig_edge_detect.v
// Trigger pin synchroniser and selectable edge detector
`timescale 1ns/1ps
module trig_edge_detect (
  // Clock and reset
  input wire ref_clk,
  input wire nrst,
  input wire clk_en,
  // Pin and selection
  input wire trig_pin,
  input wire [1:0] edge_sel,
  // Detected edge
  output reg edge_pulse
);
  reg sync1_ff;
  reg sync2_ff;
  reg prev_ff;
  wire rise;
  wire fall;
  assign rise = sync2_ff & ~prev_ff;
  assign fall = ~sync2_ff & prev_ff;
  always @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
      prev_ff <= 1'b0;
      edge_pulse <= 1'b0;
    end
    else if (clk_en)
    begin
      sync1_ff <= trig_pin;
      sync2_ff <= sync1_ff;
      prev_ff <= sync2_ff;
      // Edge kinds selected by mode field
      edge_pulse <= (edge_sel[0] & fall) | (edge_sel[1] & rise);
    end
  end
endmodule

// ### design/sar_step.v
// Successive-approximation register with trial-bit sequencing
`timescale 1ns/1ps
`include "sar_adc_map.vh"
module sar_step (
  // Clock and reset
  input wire ref_clk,
  input wire nrst,
  input wire clk_en,
  // Control
  input wire init,
  input wire decide,
  input wire [3:0] bit_idx,
  input wire cmp_ge,
  // Approximation value, also the tap code
  output reg [9:0] sar_ff
);
  always @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      sar_ff <= 10'h000;
    else if (clk_en)
    begin
      if (init)
        sar_ff <= 10'h200;
      else if (decide)
      begin
        // Keep or drop current trial bit, then set the next one
        sar_ff[bit_idx] <= cmp_ge;
        if (bit_idx != 4'd0)
          sar_ff[bit_idx - 4'd1] <= 1'b1;
      end
    end
  end
endmodule

// ### design/sar_adc_control.v
// Conversion control of a 10-bit successive-approximation converter
`timescale 1ns/1ps
`include "sar_adc_map.vh"
module sar_adc_control (
  // Clock and reset
  input wire ref_clk,
  input wire nrst,
  input wire clk_en,
  // Register access port
  input wire [15:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_wdata,
  input wire bit_wr,
  input wire [2:0] bit_sel,
  input wire bit_val,
  output reg [15:0] reg_rdata,
  // Chip state
  input wire standby,
  // Analog front end
  input wire external_trigger_in,
  input wire cmp_ge_pin,
  output reg sample_en,
  output reg hold_en,
  output reg [9:0] tap_code,
  output reg [2:0] analog_sel,
  output reg ref_gen_en,
  // Conversion end
  output reg conversion_end_irq,
  output reg conversion_end_flag,
  input wire flag_clr
);
  localparam ST_IDLE = 2'd0;
  localparam ST_WAIT = 2'd1;
  localparam ST_SAMPLE = 2'd2;
  localparam ST_CONV = 2'd3;

  reg [7:0] converter_mode_control;
  reg [7:0] input_channel_select;
  reg [15:0] conversion_result;
  reg [1:0] state_ff;
  reg [1:0] nxt_state;
  reg [7:0] cnt_ff;
  reg [7:0] nxt_cnt;
  reg [3:0] bit_ff;
  reg [3:0] nxt_bit;
  reg cmp_s1_ff;
  reg cmp_s2_ff;
  reg sar_init;
  reg sar_decide;
  reg done_ev;
  wire [9:0] sar_val;
  wire trig_edge;
  wire wr_mode;
  wire wr_chan;
  wire wr_any;
  wire run;
  wire hw_start;
  wire [7:0] conv_total;
  wire [7:0] step_cyc;
  wire [7:0] mode_next;
  wire [3:0] hit;
  wire [7:0] first_cyc;
  wire [7:0] step_lim;
  reg [15:0] nxt_rdata;

  // Total cycles for a conversion-time code
  function [7:0] conv_cycles;
    input [2:0] code;
    begin
      case (code)
        3'b000: conv_cycles = `CONV_144;
        3'b001: conv_cycles = `CONV_120;
        3'b010: conv_cycles = `CONV_96;
        3'b100: conv_cycles = `CONV_72;
        3'b101: conv_cycles = `CONV_60;
        3'b110: conv_cycles = `CONV_48;
        default: conv_cycles = `CONV_144;
      endcase
    end
  endfunction

  // One-hot register select: mode, channel, full 16-bit result word, result high byte
  function [3:0] reg_hit;
    input [15:0] addr;
    begin
      case (addr)
        `ADDR_MODE: reg_hit = 4'b0001;
        `ADDR_CHAN: reg_hit = 4'b0010;
        `ADDR_RESULT_LO: reg_hit = 4'b0100;
        `ADDR_RESULT_HI: reg_hit = 4'b1000;
        default: reg_hit = 4'b0000;
      endcase
    end
  endfunction

  assign hit = reg_hit(reg_addr);
  assign wr_mode = (reg_wr | bit_wr) & hit[0];
  assign wr_chan = reg_wr & hit[1];
  assign wr_any = wr_mode | wr_chan;
  assign mode_next = bit_wr ? (converter_mode_control & ~(8'h01 << bit_sel))
                              | ({7'h00, bit_val} << bit_sel)
                            : reg_wdata;
  assign run = converter_mode_control[`BIT_RUN] & ~standby;
  assign hw_start = converter_mode_control[`BIT_SRC];
  assign conv_total = conv_cycles(converter_mode_control[`BIT_TIME_HI:`BIT_TIME_LO]);
  // Remaining cycles divided by ten give the equal step of the last nine trials
  assign step_cyc = (conv_total - `SAMPLE_CYC) / 8'd10;
  // First trial takes the remainder so the whole conversion is exact
  assign first_cyc = conv_total - `SAMPLE_CYC - 8'd9 * step_cyc;
  assign step_lim = (bit_ff == 4'd9) ? first_cyc : step_cyc;

  trig_edge_detect u_trig (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .clk_en(clk_en),
    .trig_pin(external_trigger_in),
    .edge_sel(converter_mode_control[`BIT_EDGE_HI:`BIT_EDGE_LO]),
    .edge_pulse(trig_edge)
  );

  sar_step u_sar (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .clk_en(clk_en),
    .init(sar_init),
    .decide(sar_decide),
    .bit_idx(bit_ff),
    .cmp_ge(cmp_s2_ff),
    .sar_ff(sar_val)
  );

  // Sequencer
  always @*
  begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_bit = bit_ff;
    sar_init = 1'b0;
    sar_decide = 1'b0;
    done_ev = 1'b0;
    case (state_ff)
      ST_IDLE:
      begin
        if (run)
          nxt_state = hw_start ? ST_WAIT : ST_SAMPLE;
        nxt_cnt = 8'd0;
      end
      ST_WAIT:
      begin
        nxt_cnt = 8'd0;
        if (trig_edge)
          nxt_state = ST_SAMPLE;
      end
      ST_SAMPLE:
      begin
        nxt_cnt = cnt_ff + 8'd1;
        if (cnt_ff == `SAMPLE_CYC - 8'd1)
        begin
          // Hold, then first trial at half reference
          nxt_state = ST_CONV;
          nxt_cnt = 8'd0;
          nxt_bit = 4'd9;
          sar_init = 1'b1;
        end
      end
      ST_CONV:
      begin
        nxt_cnt = cnt_ff + 8'd1;
        if (cnt_ff == step_lim - 8'd1)
        begin
          nxt_cnt = 8'd0;
          sar_decide = 1'b1;
          if (bit_ff == 4'd0)
          begin
            done_ev = 1'b1;
            // Software start loops, trigger start waits again
            nxt_state = hw_start ? ST_WAIT : ST_SAMPLE;
          end
          else
            nxt_bit = bit_ff - 4'd1;
        end
      end
      default:
        nxt_state = ST_IDLE;
    endcase
    // Mode writes and channel byte writes restart; halt or standby stop at once
    if (wr_any)
    begin
      nxt_state = ST_IDLE;
      sar_decide = 1'b0;
      done_ev = 1'b0;
    end
    if (!run)
    begin
      nxt_state = ST_IDLE;
      done_ev = 1'b0;
    end
  end

  always @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      converter_mode_control <= `MODE_RESET;
      input_channel_select <= `CHAN_RESET;
      conversion_result <= `RESULT_RESET;
      state_ff <= ST_IDLE;
      cnt_ff <= 8'd0;
      bit_ff <= 4'd0;
      cmp_s1_ff <= 1'b0;
      cmp_s2_ff <= 1'b0;
      conversion_end_irq <= 1'b0;
      conversion_end_flag <= 1'b0;
    end
    else if (clk_en)
    begin
      cmp_s1_ff <= cmp_ge_pin;
      cmp_s2_ff <= cmp_s1_ff;
      if (wr_mode)
        converter_mode_control <= mode_next;
      if (wr_chan)
        input_channel_select <= reg_wdata & `CHAN_MASK;
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      bit_ff <= nxt_bit;
      if (done_ev)
      begin
        // Last decision merged in before loading
        conversion_result <= {sar_val[9:1], cmp_s2_ff, 6'h00};
      end
      conversion_end_irq <= done_ev;
      if (done_ev)
        conversion_end_flag <= 1'b1;
      else if (flag_clr)
        conversion_end_flag <= 1'b0;
    end
  end

  // Read data of the addressed register
  always @*
  begin
    case (hit)
      4'b0001: nxt_rdata = {8'h00, converter_mode_control};
      4'b0010: nxt_rdata = {8'h00, input_channel_select};
      4'b0100: nxt_rdata = conversion_result;
      4'b1000: nxt_rdata = {8'h00, conversion_result[15:8]};
      default: nxt_rdata = 16'h0000;
    endcase
  end

  // Registered outputs to the analog side and read port
  always @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sample_en <= 1'b0;
      hold_en <= 1'b0;
      tap_code <= 10'h000;
      analog_sel <= 3'd0;
      ref_gen_en <= 1'b0;
      reg_rdata <= 16'h0000;
    end
    else if (clk_en)
    begin
      sample_en <= (nxt_state == ST_SAMPLE);
      hold_en <= (nxt_state == ST_CONV);
      tap_code <= sar_val;
      analog_sel <= input_channel_select[2:0];
      ref_gen_en <= converter_mode_control[`BIT_REFGEN] & ~standby;
      if (reg_rd)
        reg_rdata <= nxt_rdata;
    end
  end
endmodule

// ### tb/sar_adc_chk.sv
// Assertion checker for the converter control
`timescale 1ns/1ps
module sar_adc_chk (
  // Clock and reset
  input wire ref_clk,
  input wire nrst,
  // Register access
  input wire [15:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire bit_wr,
  input wire [2:0] bit_sel,
  input wire bit_val,
  input wire [15:0] reg_rdata,
  // Conversion
  input wire standby,
  input wire sample_en,
  input wire hold_en,
  input wire ref_gen_en,
  input wire conversion_end_irq,
  input wire conversion_end_flag
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);
  sequence quiet;
    !reg_wr && !bit_wr && !standby;
  endsequence
  sequence sampling;
    $rose(sample_en) ##0 quiet[*8];
  endsequence
  chk_sample_len: assert property (sampling |=> hold_en && !sample_en)
    else $error("bad sample length");
  chk_irq_pulse: assert property (conversion_end_irq |=> !conversion_end_irq)
    else $error("end pulse too long");
  chk_irq_cause: assert property (
    $rose(conversion_end_irq) |-> $past(hold_en) || $past(hold_en, 2))
    else $error("end without search");
  chk_flag_set: assert property (conversion_end_irq |-> ##[0:1] conversion_end_flag)
    else $error("end flag not set");
  chk_standby_stop: assert property (
    standby[*3] |-> !sample_en && !hold_en && !ref_gen_en)
    else $error("active in standby");
  chk_run_halt: assert property (
    (bit_wr && reg_addr == 16'hff80 && bit_sel == 3'd7 && !bit_val) ##1 quiet[*2]
    |=> !sample_en && !hold_en)
    else $error("run clear did not stop");
  chk_result_align: assert property (
    reg_rd && reg_addr == 16'hff16 |=> reg_rdata[5:0] == 6'h00)
    else $error("result low bits set");
  chk_chan_upper: assert property (
    reg_rd && reg_addr == 16'hff81 |=> reg_rdata[15:3] == 13'h0000)
    else $error("channel upper bits set");
endmodule
bind sar_adc_control sar_adc_chk u_chk (.ref_clk, .nrst, .reg_addr, .reg_wr, .reg_rd, .bit_wr,
  .bit_sel, .bit_val, .reg_rdata, .standby, .sample_en, .hold_en, .ref_gen_en,
  .conversion_end_irq, .conversion_end_flag);

// ### tb/sar_front_model.sv
// Comparator front end model
`timescale 1ns/1ps
module sar_front_model (
  // Clock
  input wire ref_clk,
  // Converter side
  input wire sample_en,
  input wire hold_en,
  input wire [9:0] tap_code,
  input wire [9:0] vin,
  output wire cmp_ge
);
  reg [9:0] held_ff = 10'h000;
  reg idle_ff = 1'b0;
  always @(posedge ref_clk)
  begin
    idle_ff <= ~idle_ff;
    if (sample_en)
      held_ff <= vin;
  end
  // Held input at or above the tap gives a high decision
  assign cmp_ge = hold_en ? (held_ff >= tap_code) : idle_ff;
endmodule

// ### tb/tb_top.sv
// Self-checking bench for the converter control
`timescale 1ns/1ps
module tb_top;
  reg ref_clk = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, bit_wr = 1'b0;
  reg bit_val = 1'b0, standby = 1'b0, trig = 1'b0, flag_clr = 1'b0;
  reg [15:0] reg_addr = 16'h0000;
  reg [7:0] reg_wdata = 8'h00;
  reg [2:0] bit_sel = 3'h0;
  reg [9:0] vin = 10'h000;
  wire [15:0] reg_rdata;
  wire [9:0] tap_code;
  wire [2:0] analog_sel;
  wire cmp_ge, sample_en, hold_en, ref_gen_en, irq, flag;
  integer fails = 0, n_tests = 0, n_irq = 0, hlen = 0, i, k;
  integer exp_q[$];
  always #12.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
    n_irq <= n_irq + (irq === 1'b1);
  sar_adc_control u_dut (.ref_clk, .nrst, .clk_en(1'b1), .reg_addr, .reg_wr, .reg_rd,
    .reg_wdata, .bit_wr, .bit_sel, .bit_val, .reg_rdata, .standby,
    .external_trigger_in(trig), .cmp_ge_pin(cmp_ge), .sample_en, .hold_en, .tap_code,
    .analog_sel, .ref_gen_en, .conversion_end_irq(irq), .conversion_end_flag(flag), .flag_clr);
  sar_front_model u_fe (.ref_clk, .sample_en, .hold_en, .tap_code, .vin, .cmp_ge);
  task cmp(input [15:0] got, input [15:0] exp);
  begin
    n_tests = n_tests + 1;
    if (got !== exp)
    begin
      fails = fails + 1;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  end
  endtask
  task bus(input [15:0] a, input [7:0] d, input [1:0] op);
  begin
    @(negedge ref_clk);
    reg_addr = a;
    reg_wdata = d;
    {bit_sel, bit_val} = d[3:0];
    {bit_wr, reg_wr, reg_rd} = 3'b001 << op;
    @(negedge ref_clk);
    {bit_wr, reg_wr, reg_rd} = 3'b000;
  end
  endtask
  task rd(input [15:0] a, input [15:0] e);
  begin
    bus(a, 8'h00, 2'd0);
    cmp(reg_rdata, e);
  end
  endtask
  task conv;
  integer k0, e0;
  begin
    k0 = n_irq;
    hlen = 0;
    repeat (400)
      if (n_irq == k0)
      begin
        @(negedge ref_clk);
        hlen = hlen + hold_en;
      end
    cmp(n_irq - k0, 1);
    cmp(flag, 1'b1);
    e0 = exp_q.pop_front();
    rd(16'hff16, e0);
    rd(16'hff17, e0 >> 8);
  end
  endtask
  task end_sim;
  begin
    $display("fails=%0d n_tests=%0d", fails, n_tests);
    if (fails == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  end
  endtask
  initial
  begin
    #(30000 * 25);
    fails = fails + 1;
    end_sim;
  end
  initial
  begin
    k = $urandom(32'h396e6883);
    repeat (2) @(negedge ref_clk);
    nrst = 1'b1;
    rd(16'hff80, 16'h0000);
    rd(16'hff81, 16'h0000);
    rd(16'hff16, 16'h0000);
    rd(16'hff40, 16'h0000);
    bus(16'hff81, 8'hfd, 2'd1);
    rd(16'hff81, 16'h0005);
    bus(16'hff80, 8'h7e, 2'd1);
    bus(16'hff80, {3'd6, 1'b0}, 2'd2);
    rd(16'hff80, 16'h003e);
    bus(16'hff80, {3'd0, 1'b1}, 2'd2);
    repeat (560) @(negedge ref_clk);
    cmp(ref_gen_en, 1'b1);
    for (i = 0; i < 6; i = i + 1)
    begin
      vin = $urandom;
      exp_q.push_back(vin * 64);
      bus(16'hff80, 8'h81 | ((i + (i > 2)) << 3), 2'd1);
      conv;
      cmp(hlen, (i < 3 ? 136 - 24 * i : 64 - 12 * (i - 3)));
      vin = $urandom;
      exp_q.push_back(vin * 64);
      conv;
      @(posedge hold_en);
      vin = $urandom;
      exp_q.push_back(vin * 64);
      bus(16'hff81, i, 2'd1);
      conv;
      cmp(analog_sel, i);
      @(posedge hold_en);
      k = n_irq;
      bus(16'hff80, {3'd7, 1'b0}, 2'd2);
      repeat (200) @(negedge ref_clk);
      cmp(n_irq - k, 0);
      @(negedge ref_clk) flag_clr = 1'b1;
      @(negedge ref_clk) flag_clr = 1'b0;
      cmp(flag, 1'b0);
    end
    bus(16'hff80, 8'h81, 2'd1);
    @(posedge hold_en);
    k = n_irq;
    @(negedge ref_clk) standby = 1'b1;
    repeat (50) @(negedge ref_clk);
    cmp(n_irq - k, 0);
    cmp(ref_gen_en, 1'b0);
    vin = $urandom;
    exp_q.push_back(vin * 64);
    standby = 1'b0;
    conv;
    for (i = 0; i < 4; i = i + 1)
    begin
      bus(16'hff80, 8'hc1 | (i << 1), 2'd1);
      k = n_irq;
      trig = 1'b1;
      repeat (250) @(negedge ref_clk);
      cmp(n_irq - k, i / 2);
      k = n_irq;
      trig = 1'b0;
      repeat (250) @(negedge ref_clk);
      cmp(n_irq - k, i % 2);
    end
    bus(16'hff80, {3'd7, 1'b0}, 2'd2);
    bus(16'hff80, {3'd0, 1'b0}, 2'd2);
    end_sim;
  end
endmodule
